// file: design/ptd_target_decode.sv
`timescale 1ns/10ps
module ptd_target_decode (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pci_reset,
  input wire logic config_disable_strap,
  input wire logic eeprom_present_strap,
  input wire logic sda_strap,
  input wire logic ee_load,
  input wire logic ee_bar0_bit,
  input wire logic ee_bar1_bit,
  input wire logic [3:0] ee_img1_size,
  input wire logic ee_img1_space,
  input wire logic [15:0] config_base_reg_0,
  input wire logic [15:0] config_base_reg_1,
  input wire logic config_base_1_io,
  input ptd_pkg::ptd_img0_ctl_t img0_ctl,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pci_addr_valid,
  input wire logic [31:0] pci_addr,
  input wire logic pci_io,
  input wire logic pci_write,
  output ptd_pkg::ptd_claim_t claim
);
  import ptd_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    ptd_state_t st;
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] img0_ba;
    logic [15:0] img0_ta;
    logic img1_en;
    logic [3:0] img1_size;
    logic img1_space;
    ptd_attr_t img1_attr;
    logic [15:0] img1_ba;
    logic [15:0] img1_ta;
    logic byte_order;
    ptd_claim_t claim;
  } ptd_top_state_t;

  ptd_top_state_t s_reg;
  ptd_top_state_t s_next;
  ptd_straps_t straps;
  ptd_image_t img0_eff;
  ptd_image_t img1_eff;
  logic hit0;
  logic hit1;
  logic [31:0] laddr0;
  logic [31:0] laddr1;
  logic img1_fields_ro;

  function automatic logic [31:0] wmerge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    wmerge = r;
  endfunction

  // ==========================================================
  // Strap capture and image decoders
  // ==========================================================
  ptd_strap_capture u_straps (
    .ref_clk(ref_clk),
    .reset(reset),
    .pci_reset(pci_reset),
    .config_disable_strap(config_disable_strap),
    .eeprom_present_strap(eeprom_present_strap),
    .sda_strap(sda_strap),
    .ee_load(ee_load),
    .ee_bar0_bit(ee_bar0_bit),
    .ee_bar1_bit(ee_bar1_bit),
    .straps(straps)
  );

  // Fields loaded by the EEPROM lock unless the disable strap is set.
  assign img1_fields_ro = straps.img1_loaded && !straps.cfg_dis;

  always_comb begin
    img0_eff.enable = img0_ctl.enable;
    img0_eff.window_size_code = img0_ctl.window_size_code;
    img0_eff.space_select = img0_ctl.space_select;
    img0_eff.base = straps.bar0_on ? config_base_reg_0
      : s_reg.img0_ba;
    img0_eff.translation_field = s_reg.img0_ta;
    img1_eff.enable = s_reg.img1_en;
    img1_eff.window_size_code = s_reg.img1_size;
    img1_eff.space_select = img1_fields_ro ? config_base_1_io
      : s_reg.img1_space;
    img1_eff.base = straps.bar1_on ? config_base_reg_1
      : s_reg.img1_ba;
    img1_eff.translation_field = s_reg.img1_ta;
  end

  ptd_image_decode u_dec0 (
    .image(img0_eff),
    .pci_addr(pci_addr),
    .pci_io(pci_io),
    .hit(hit0),
    .local_addr(laddr0)
  );

  ptd_image_decode u_dec1 (
    .image(img1_eff),
    .pci_addr(pci_addr),
    .pci_io(pci_io),
    .hit(hit1),
    .local_addr(laddr1)
  );

  // ==========================================================
  // Register read view
  // ==========================================================
  function automatic logic [31:0] rd_value(input logic [8:0] a,
                                           input ptd_top_state_t s,
                                           input ptd_image_t i0,
                                           input ptd_image_t i1,
                                           input ptd_straps_t sp);
    logic [31:0] v;
    v = PTD_WORD_RST;
    if (a == PTD_IMG0_ADDR_OFS) begin
      v[PTD_BA_LSB +: 16] = i0.base;
      v[PTD_TA_LSB +: 16] = s.img0_ta;
    end else if (a == PTD_IMG1_CTL_OFS) begin
      v[PTD_EN_BIT] = s.img1_en;
      v[PTD_SIZE_LSB +: 4] = s.img1_size;
      v[PTD_PREFETCH_ENABLE_BIT] = s.img1_attr.prefetch_enable;
      v[PTD_BURST_BIT] = s.img1_attr.burst_write_enable;
      v[PTD_ENDIAN_INVERT_BIT] = s.img1_attr.endian_invert;
      v[PTD_TC_LSB +: 4] = s.img1_attr.local_txn_code;
      v[PTD_WIDTH_LSB +: 2] = s.img1_attr.port_width;
      v[PTD_POSTING_ENABLE_BIT] = s.img1_attr.posting_enable;
      v[PTD_SPACE_BIT] = i1.space_select;
    end else if (a == PTD_IMG1_ADDR_OFS) begin
      v[PTD_BA_LSB +: 16] = i1.base;
      v[PTD_TA_LSB +: 16] = s.img1_ta;
    end else if (a == PTD_MISC_OFS) begin
      v[PTD_ORDER_BIT] = s.byte_order;
    end else if (a == PTD_STATUS_OFS) begin
      v[4:0] = sp;
    end
    rd_value = v;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic [31:0] cur;
    logic [31:0] mw;
    cur = rd_value(avs_address, s_reg, img0_eff, img1_eff, straps);
    mw = wmerge(cur, avs_writedata, avs_byteenable);
    s_next = s_reg;
    s_next.claim.valid = 1'b0;

    // Avalon slave: one wait cycle, then the answer for one cycle.
    case (s_reg.st)
      PTD_IDLE: begin
        if (avs_read || avs_write) begin
          s_next.st = PTD_ACK;
          s_next.waitreq = 1'b0;
          if (avs_read) begin
            s_next.rdata = cur;
          end
        end
      end
      PTD_ACK: begin
        s_next.st = PTD_IDLE;
        s_next.waitreq = 1'b1;
        if (avs_write) begin
          if (avs_address == PTD_IMG0_ADDR_OFS) begin
            if (!straps.bar0_on) begin
              s_next.img0_ba = mw[PTD_BA_LSB +: 16];
            end
            s_next.img0_ta = mw[PTD_TA_LSB +: 16];
          end else if (avs_address == PTD_IMG1_CTL_OFS) begin
            s_next.img1_en = mw[PTD_EN_BIT];
            s_next.img1_attr.prefetch_enable = mw[PTD_PREFETCH_ENABLE_BIT];
            s_next.img1_attr.burst_write_enable = mw[PTD_BURST_BIT];
            s_next.img1_attr.endian_invert = mw[PTD_ENDIAN_INVERT_BIT];
            s_next.img1_attr.local_txn_code = mw[PTD_TC_LSB +: 4];
            s_next.img1_attr.port_width =
              ptd_width_t'(mw[PTD_WIDTH_LSB +: 2]);
            s_next.img1_attr.posting_enable = mw[PTD_POSTING_ENABLE_BIT];
            if (!img1_fields_ro) begin
              s_next.img1_size = mw[PTD_SIZE_LSB +: 4];
              s_next.img1_space = mw[PTD_SPACE_BIT];
            end
          end else if (avs_address == PTD_IMG1_ADDR_OFS) begin
            if (!straps.bar1_on) begin
              s_next.img1_ba = mw[PTD_BA_LSB +: 16];
            end
            s_next.img1_ta = mw[PTD_TA_LSB +: 16];
          end else if (avs_address == PTD_MISC_OFS) begin
            s_next.byte_order = mw[PTD_ORDER_BIT];
          end
        end
      end
      default: begin
        s_next.st = PTD_IDLE;
        s_next.waitreq = 1'b1;
      end
    endcase

    // PCI reset clears only its own fields and wins over a bus write.
    if (pci_reset) begin
      s_next.img0_ba = PTD_FIELD16_RST;
      s_next.img1_ba = PTD_FIELD16_RST;
      s_next.img1_size = PTD_NIBBLE_RST;
      s_next.img1_space = 1'b0;
    end else if (ee_load && straps.ee_present && ee_bar1_bit) begin
      s_next.img1_size = ee_img1_size;
      s_next.img1_space = ee_img1_space;
    end

    // Image 0 takes precedence if software lets the windows overlap.
    if (pci_addr_valid && (hit0 || hit1)) begin
      s_next.claim.valid = 1'b1;
      s_next.claim.image = !hit0;
      if (hit0) begin
        s_next.claim.local_addr = laddr0;
        s_next.claim.port_width = img0_ctl.attr.port_width;
        s_next.claim.big_endian =
          s_reg.byte_order ^ img0_ctl.attr.endian_invert;
        s_next.claim.posted = pci_write && !pci_io
          && img0_ctl.attr.posting_enable;
        s_next.claim.prefetch = img0_ctl.attr.prefetch_enable;
        s_next.claim.burst_write = img0_ctl.attr.burst_write_enable;
        s_next.claim.local_txn_code = img0_ctl.attr.local_txn_code;
      end else begin
        s_next.claim.local_addr = laddr1;
        s_next.claim.port_width = s_reg.img1_attr.port_width;
        s_next.claim.big_endian =
          s_reg.byte_order ^ s_reg.img1_attr.endian_invert;
        s_next.claim.posted = pci_write && !pci_io
          && s_reg.img1_attr.posting_enable;
        s_next.claim.prefetch = s_reg.img1_attr.prefetch_enable;
        s_next.claim.burst_write = s_reg.img1_attr.burst_write_enable;
        s_next.claim.local_txn_code = s_reg.img1_attr.local_txn_code;
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.st <= PTD_IDLE;
      s_reg.waitreq <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = s_reg.waitreq;
  assign claim = s_reg.claim;

endmodule // ptd_target_decode

// file: design/ptd_pkg.sv
package ptd_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [8:0] PTD_IMG0_ADDR_OFS = 9'h104;
  localparam logic [8:0] PTD_IMG1_CTL_OFS = 9'h110;
  localparam logic [8:0] PTD_IMG1_ADDR_OFS = 9'h114;
  localparam logic [8:0] PTD_MISC_OFS = 9'h1F0;
  localparam logic [8:0] PTD_STATUS_OFS = 9'h1F4;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int PTD_EN_BIT = 31;
  localparam int PTD_SIZE_LSB = 24;
  localparam int PTD_PREFETCH_ENABLE_BIT = 23;
  localparam int PTD_BURST_BIT = 22;
  localparam int PTD_ENDIAN_INVERT_BIT = 19;
  localparam int PTD_TC_LSB = 12;
  localparam int PTD_WIDTH_LSB = 10;
  localparam int PTD_POSTING_ENABLE_BIT = 7;
  localparam int PTD_SPACE_BIT = 6;
  localparam int PTD_BA_LSB = 16;
  localparam int PTD_TA_LSB = 0;
  localparam int PTD_ORDER_BIT = 0;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [15:0] PTD_FIELD16_RST = 16'h0000;
  localparam logic [3:0] PTD_NIBBLE_RST = 4'h0;
  localparam logic [31:0] PTD_WORD_RST = 32'h0000_0000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    PTD_W32 = 2'b00,
    PTD_W8 = 2'b01,
    PTD_W16 = 2'b10,
    PTD_WRSV = 2'b11
  } ptd_width_t;

  typedef enum logic {
    PTD_IDLE = 1'b0,
    PTD_ACK = 1'b1
  } ptd_state_t;

  typedef struct packed {
    logic prefetch_enable;
    logic burst_write_enable;
    logic endian_invert;
    logic [3:0] local_txn_code;
    ptd_width_t port_width;
    logic posting_enable;
  } ptd_attr_t;

  typedef struct packed {
    logic enable;
    logic [3:0] window_size_code;
    logic space_select;
    ptd_attr_t attr;
  } ptd_img0_ctl_t;

  typedef struct packed {
    logic enable;
    logic [3:0] window_size_code;
    logic space_select;
    logic [15:0] base;
    logic [15:0] translation_field;
  } ptd_image_t;

  typedef struct packed {
    logic cfg_dis;
    logic ee_present;
    logic bar0_on;
    logic bar1_on;
    logic img1_loaded;
  } ptd_straps_t;

  typedef struct packed {
    logic valid;
    logic image;
    logic [31:0] local_addr;
    ptd_width_t port_width;
    logic big_endian;
    logic posted;
    logic prefetch;
    logic burst_write;
    logic [3:0] local_txn_code;
  } ptd_claim_t;

  // Lines 31..16+code take part in compare and substitution.
  function automatic logic [15:0] ptd_upper_mask(input logic [3:0] code);
    ptd_upper_mask = 16'hFFFF << code;
  endfunction

endpackage

// file: design/ptd_strap_capture.sv
`timescale 1ns/10ps
module ptd_strap_capture (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pci_reset,
  input wire logic config_disable_strap,
  input wire logic eeprom_present_strap,
  input wire logic sda_strap,
  input wire logic ee_load,
  input wire logic ee_bar0_bit,
  input wire logic ee_bar1_bit,
  output ptd_pkg::ptd_straps_t straps
);
  import ptd_pkg::*;

  ptd_straps_t st_reg;
  ptd_straps_t st_next;

  // Pins are sampled on every clock while PCI reset is held, so the
  // value kept is the one present at the last edge before release.
  always_comb begin
    st_next = st_reg;
    if (pci_reset) begin
      st_next.cfg_dis = config_disable_strap;
      st_next.ee_present = eeprom_present_strap | sda_strap;
      st_next.bar0_on = config_disable_strap;
      st_next.bar1_on = config_disable_strap;
      st_next.img1_loaded = 1'b0;
    end else if (ee_load && st_reg.ee_present) begin
      st_next.bar0_on = st_reg.cfg_dis | ee_bar0_bit;
      st_next.bar1_on = st_reg.cfg_dis | ee_bar1_bit;
      st_next.img1_loaded = ee_bar1_bit;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign straps = st_reg;

endmodule // ptd_strap_capture

// file: design/ptd_image_decode.sv
`timescale 1ns/10ps
module ptd_image_decode (
  input ptd_pkg::ptd_image_t image,
  input wire logic [31:0] pci_addr,
  input wire logic pci_io,
  output logic hit,
  output logic [31:0] local_addr
);
  import ptd_pkg::*;

  logic [15:0] mask;

  always_comb begin
    mask = ptd_upper_mask(image.window_size_code);
    hit = image.enable && (pci_io == image.space_select)
      && ((pci_addr[31:16] & mask) == (image.base & mask));
    local_addr = {(image.translation_field & mask)
      | (pci_addr[31:16] & ~mask), pci_addr[15:0]};
  end

endmodule // ptd_image_decode

// file: test/ptd_target_decode_assertions.sv
`timescale 1ns/10ps
// ====================
// Port checks
// ====================
module ptd_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pci_addr_valid,
  input wire logic [31:0] pci_addr,
  input wire logic pci_io,
  input wire logic pci_write,
  input ptd_pkg::ptd_claim_t claim
);
  import ptd_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic req;
  logic mapped;
  assign req = avs_read | avs_write;
  assign mapped = avs_address inside {PTD_IMG0_ADDR_OFS, PTD_IMG1_CTL_OFS,
    PTD_IMG1_ADDR_OFS, PTD_MISC_OFS, PTD_STATUS_OFS};
  sequence taken_s;
    req && avs_waitrequest;
  endsequence
  sequence answer_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  one_wait_a: assert property (taken_s |=> answer_s)
    else $error("request not answered after one wait cycle");
  answer_cause_a: assert property (!avs_waitrequest |->
    $past(req) && $past(avs_waitrequest))
    else $error("answer without a request");
  readdata_hold_a: assert property (avs_waitrequest &&
    $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved outside an answer");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    !mapped |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  claim_cause_a: assert property (claim.valid |-> $past(pci_addr_valid))
    else $error("claim without an address phase");
  low_lines_a: assert property (claim.valid |->
    claim.local_addr[15:0] == $past(pci_addr[15:0]))
    else $error("low address lines altered");
  io_no_post_a: assert property (claim.valid && $past(pci_io) |->
    !claim.posted)
    else $error("io write posted");
  post_write_a: assert property (claim.valid && claim.posted |->
    $past(pci_write) && !$past(pci_io))
    else $error("posted claim not a memory write");
  claim_hold_a: assert property (!claim.valid |->
    $stable(claim.local_addr))
    else $error("claim address moved between claims");
endmodule // ptd_checker

bind ptd_target_decode ptd_checker ptd_checker_inst (.ref_clk, .reset,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .pci_addr_valid, .pci_addr, .pci_io, .pci_write, .claim);

// file: test/ptd_pci_master.sv
`timescale 1ns/10ps
// ====================
// PCI initiator model
// ====================
module ptd_pci_master (
  input wire logic ref_clk,
  output logic pci_addr_valid,
  output logic [31:0] pci_addr,
  output logic pci_io,
  output logic pci_write
);
  initial begin
    pci_addr_valid = 1'b0;
    pci_addr = 32'h0;
    pci_io = 1'b0;
    pci_write = 1'b0;
  end
  task automatic phase(input logic [31:0] a, input logic io,
    input logic w);
    pci_addr_valid <= 1'b1;
    pci_addr <= a;
    pci_io <= io;
    pci_write <= w;
    @(posedge ref_clk);
  endtask
  // Lines are not held between phases, so they flip to expose stale use.
  task automatic idle();
    pci_addr_valid <= 1'b0;
    pci_addr <= ~pci_addr;
    pci_io <= ~pci_io;
    pci_write <= ~pci_write;
    @(posedge ref_clk);
  endtask
endmodule // ptd_pci_master

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import ptd_pkg::*;
  logic ref_clk, reset, pci_reset, config_disable_strap;
  logic eeprom_present_strap, sda_strap, ee_load, ee_bar0_bit, ee_bar1_bit;
  logic [3:0] ee_img1_size;
  logic ee_img1_space, config_base_1_io;
  logic [15:0] config_base_reg_0, config_base_reg_1;
  ptd_img0_ctl_t img0_ctl;
  logic [8:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic pci_addr_valid, pci_io, pci_write;
  logic [31:0] pci_addr;
  ptd_claim_t claim;
  ptd_claim_t exp_q[$];
  ptd_claim_t exp0;
  int err_total;
  int checks_done;

  ptd_target_decode ptd_target_decode_inst (.ref_clk, .reset, .pci_reset,
    .config_disable_strap, .eeprom_present_strap, .sda_strap, .ee_load,
    .ee_bar0_bit, .ee_bar1_bit, .ee_img1_size, .ee_img1_space,
    .config_base_reg_0, .config_base_reg_1, .config_base_1_io, .img0_ctl,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .pci_addr_valid, .pci_addr, .pci_io,
    .pci_write, .claim);
  ptd_pci_master ptd_pci_master_inst (.ref_clk, .pci_addr_valid,
    .pci_addr, .pci_io, .pci_write);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ====================
  // Shared tasks
  // ====================
  task automatic check(input string n, input logic [63:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic av(input logic w, input logic [8:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d,
    input logic [3:0] be);
    logic [31:0] q;
    av(1'b1, a, d, be, q);
  endtask
  task automatic rd_chk(input string n, input logic [8:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    av(1'b0, a, 32'h0, 4'hF, q);
    check(n, 64'(q), 64'(e));
  endtask
  // Straps are latched on the last held edge; the EEPROM pulse follows.
  task automatic prst(input logic dis, input logic ee);
    pci_reset <= 1'b1;
    config_disable_strap <= dis;
    eeprom_present_strap <= ee;
    ee_bar0_bit <= ee;
    ee_bar1_bit <= ee;
    repeat (2) @(posedge ref_clk);
    pci_reset <= 1'b0;
    ee_load <= ee;
    @(posedge ref_clk);
    ee_load <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic img(input logic [3:0] k, input logic sp);
    logic [31:0] ctl, m, a, r;
    logic [15:0] ba, ta;
    ptd_claim_t e;
    ba = 16'($urandom);
    ta = k[3] ? ba : 16'($urandom);
    ctl = {1'b1, 3'h0, k, k[2], k[3], 2'h0, k[0], 3'h0, k, k[1:0], 2'h0,
      1'b1, sp, 6'h0};
    wr(PTD_IMG1_CTL_OFS, ctl, 4'hF);
    wr(PTD_IMG1_ADDR_OFS, {ba, ta}, 4'hF);
    rd_chk("control", PTD_IMG1_CTL_OFS, ctl);
    rd_chk("address", PTD_IMG1_ADDR_OFS, {ba, ta});
    m = 32'hFFFF_0000 << k;
    repeat (3) begin
      r = $urandom;
      a = ({ba, 16'h0} & m) | (r & ~m);
      e = '0;
      e.valid = 1'b1;
      e.image = 1'b1;
      e.local_addr = ({ta, 16'h0} & m) | (a & ~m);
      if (ta == ba) begin
        e.local_addr = a;
      end
      e.port_width = ptd_width_t'(k[1:0]);
      e.big_endian = !k[0];
      e.posted = r[0] & !sp;
      e.prefetch = k[2];
      e.burst_write = k[3];
      e.local_txn_code = k;
      exp_q.push_back(e);
      ptd_pci_master_inst.phase(a, sp, r[0]);
      ptd_pci_master_inst.phase(a ^ (32'h1 << (16 + k)), sp, r[0]);
      ptd_pci_master_inst.phase(a, !sp, r[0]);
    end
    ptd_pci_master_inst.idle();
  endtask

  // ====================
  // Claim watcher
  // ====================
  always @(posedge ref_clk) begin
    if (!reset && claim.valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("stray claim", 64'(claim), 64'h0);
      else
        check("claim", 64'(claim), 64'(exp_q.pop_front()));
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    summarize();
  end

  // ====================
  // Main sequence
  // ====================
  initial begin
    err_total = 0;
    checks_done = 0;
    {reset, pci_reset, config_disable_strap, eeprom_present_strap} = 4'hC;
    {sda_strap, ee_load, ee_bar0_bit, ee_bar1_bit} = 4'h0;
    {ee_img1_size, ee_img1_space, config_base_1_io} = 6'h0;
    config_base_reg_0 = 16'h0;
    config_base_reg_1 = 16'h0;
    img0_ctl = '0;
    {avs_address, avs_read, avs_write} = 11'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    void'($urandom(32'hA886));
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    prst(1'b0, 1'b0);
    rd_chk("control reset", PTD_IMG1_CTL_OFS, 32'h0);
    rd_chk("address1 reset", PTD_IMG1_ADDR_OFS, 32'h0);
    rd_chk("address0 reset", PTD_IMG0_ADDR_OFS, 32'h0);
    wr(9'h108, 32'hFFFF_FFFF, 4'hF);
    rd_chk("unmapped", 9'h108, 32'h0);
    wr(PTD_MISC_OFS, 32'h1, 4'hF);
    rd_chk("byte order", PTD_MISC_OFS, 32'h1);
    for (int k = 0; k < 16; k++) img(k[3:0], k[2]);
    wr(PTD_IMG1_ADDR_OFS, 32'h1234_5678, 4'hF);
    wr(PTD_IMG1_ADDR_OFS, 32'hABCD_4321, 4'h3);
    rd_chk("lane write", PTD_IMG1_ADDR_OFS, 32'h1234_4321);
    config_base_reg_0 <= 16'hA5C3;
    config_base_reg_1 <= 16'h5A3C;
    config_base_1_io <= 1'b1;
    ee_img1_size <= 4'h5;
    prst(1'b0, 1'b1);
    rd_chk("base0 mirror", PTD_IMG0_ADDR_OFS, 32'hA5C3_0000);
    wr(PTD_IMG1_ADDR_OFS, 32'hFFFF_0000, 4'hF);
    rd_chk("base1 mirror", PTD_IMG1_ADDR_OFS, 32'h5A3C_0000);
    wr(PTD_IMG1_CTL_OFS, 32'h0F00_0000, 4'hF);
    rd_chk("locked size", PTD_IMG1_CTL_OFS, 32'h0500_0040);
    prst(1'b1, 1'b1);
    rd_chk("straps", PTD_STATUS_OFS, 32'h0000_001F);
    wr(PTD_IMG1_CTL_OFS, 32'h0A00_0000, 4'hF);
    rd_chk("strap size", PTD_IMG1_CTL_OFS, 32'h0A00_0000);
    wr(PTD_IMG1_ADDR_OFS, 32'h0000_7777, 4'hF);
    rd_chk("strap mirror", PTD_IMG1_ADDR_OFS, 32'h5A3C_7777);
    prst(1'b0, 1'b0);
    rd_chk("base cleared", PTD_IMG1_ADDR_OFS, 32'h0000_7777);
    // Image 0 is driven from outside, so its claim path needs its own phase.
    wr(PTD_IMG0_ADDR_OFS, 32'h8001_0123, 4'hF);
    rd_chk("address0", PTD_IMG0_ADDR_OFS, 32'h8001_0123);
    img0_ctl <= '{enable: 1'b1, window_size_code: 4'h1, space_select: 1'b0,
      attr: '{1'b1, 1'b0, 1'b1, 4'h9, PTD_W16, 1'b1}};
    exp0 = '{1'b1, 1'b0, 32'h0122_ABCD, PTD_W16, 1'b0, 1'b1, 1'b1, 1'b0,
      4'h9};
    exp_q.push_back(exp0);
    ptd_pci_master_inst.phase(32'h8000_ABCD, 1'b0, 1'b1);
    ptd_pci_master_inst.idle();
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd_chk("global reset", PTD_IMG1_ADDR_OFS, 32'h0);
    repeat (3) @(posedge ref_clk);
    check("pending claims", 64'(exp_q.size()), 64'h0);
    summarize();
  end
endmodule // testbench
